// >>> core/nic_core.sv
// Purpose: Nested vectored interrupt controller beside the CPU core
// Assumes: CPU obeys the hold/push/vector strobes one per cycle
// Notes:   Registers reached over APB, answer with no wait state
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module nic_core
  import nic_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire nic_cpu_req_t       cpu_req,
  output nic_cpu_ctl_t            cpu_ctl,
  output logic [7:0]              cc_value,
  input  wire logic               top_irq_pin,
  input  wire logic [15:0]        ext_pin,
  input  wire logic [NUM_VEC-1:0] periph_flag,
  input  wire logic [NUM_VEC-1:0] periph_en,
  input  wire logic [NUM_VEC-1:0] periph_clr
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]              cc_q;
  logic [1:0]              isp_q [NUM_VEC];
  logic [15:0]             ext_sel_q;
  logic [4:0]              ctrl_q;
  logic [16:0]             pin_s1_q;
  logic [16:0]             pin_s2_q;
  logic                    top_prev_q;
  logic [NUM_GRP-1:0]      grp_prev_q;
  logic [NUM_GRP-1:0]      grp_now;
  logic [NUM_VEC-1:0]      edge_set;
  logic [NUM_VEC-1:0]      edge_pend_q;
  logic [NUM_VEC-1:0]      per_pend_q;
  logic [NUM_VEC-1:0]      pending;
  logic [NUM_VEC-1:0]      eligible;
  logic [NUM_VEC-1:0][2:0] rank;
  logic                    win_valid;
  logic [3:0]              win_idx;
  logic                    reset_pend_q;
  logic                    trap_pend_q;
  logic                    top_active_q;
  nic_state_t              state_q;
  nic_sleep_t              sleep_q;
  logic                    sel_nmi_q;
  logic                    sel_reset_q;
  logic                    sel_trap_q;
  logic [3:0]              sel_idx_q;
  logic                    boundary;
  logic                    take;
  logic                    take_mask;
  logic [1:0]              cur_lvl;
  logic                    apb_wr;
  logic [31:0]             rd_data;
  logic                    rd_err;

  function automatic logic [2:0] lvl_rank(input logic [1:0] code);
    case (code)
      LVL0:    lvl_rank = 3'h0;
      LVL1:    lvl_rank = 3'h1;
      LVL2:    lvl_rank = 3'h2;
      default: lvl_rank = 3'h3;
    endcase
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apb_wr = psel && penable && pwrite && pready;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr)
      OFS_CC:      rd_data[7:0] = cc_q;
      OFS_EXT_SEL: rd_data[15:0] = ext_sel_q;
      OFS_CTRL:    rd_data[4:0] = ctrl_q;
      OFS_STATUS:  rd_data = {11'h000, top_active_q, trap_pend_q,
                              reset_pend_q, sleep_q, state_q, pending};
      default: begin
        if (paddr >= OFS_PRIO0 && paddr <= OFS_PRIO3 && paddr[1:0] == 2'h0)
        begin
          for (int j = 0; j < 4; j++) begin
            if (4 * int'((paddr - OFS_PRIO0) >> 2) + j < NUM_VEC) begin
              rd_data[2*j+:2] = isp_q[4 * int'((paddr - OFS_PRIO0) >> 2) + j];
            end else begin
              rd_data[2*j+:2] = 2'h3;
            end
          end
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // No wait state: answer raised in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_q <= EXT_SEL_RESET;
      ctrl_q    <= CTRL_RESET;
    end else if (apb_wr && paddr == OFS_EXT_SEL) begin
      ext_sel_q <= pwdata[15:0];
    end else if (apb_wr && paddr == OFS_CTRL) begin
      ctrl_q <= pwdata[4:0];
    end
  end

  // ----------------------------------------
  // Software priority fields
  // ----------------------------------------
  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_isp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          isp_q[gv] <= PRIO_RESET[1:0];
        end else if (apb_wr && paddr == OFS_PRIO0 + 12'(4 * (gv / 4))) begin
          // level 0 code keeps old value
          if (pwdata[2*(gv%4)+:2] != LVL0) begin
            isp_q[gv] <= pwdata[2*(gv%4)+:2];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisers and edge latches
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q   <= 17'h00000;
      pin_s2_q   <= 17'h00000;
      top_prev_q <= 1'b0;
      grp_prev_q <= '0;
    end else begin
      pin_s1_q   <= {top_irq_pin, ext_pin};
      pin_s2_q   <= pin_s1_q;
      top_prev_q <= pin_s2_q[16];
      grp_prev_q <= grp_now;
    end
  end

  always_comb begin
    edge_set = '0;
    // selected pins of a group ORed
    for (int g = 0; g < NUM_GRP; g++) begin
      grp_now[g] = |(ext_sel_q[GRP_PINS*g+:GRP_PINS] &
                     pin_s2_q[GRP_PINS*g+:GRP_PINS]);
      edge_set[EXT_VEC0+g] = ctrl_q[CTRL_EXT_RISE+g] ?
                             (grp_now[g] && !grp_prev_q[g]) :
                             (!grp_now[g] && grp_prev_q[g]);
    end
    // chosen edge on the top pin
    edge_set[0] = ctrl_q[CTRL_TOP_RISE] ? (pin_s2_q[16] && !top_prev_q) :
                                          (!pin_s2_q[16] && top_prev_q);
  end

  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_pend
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          edge_pend_q[gv] <= 1'b0;
        end else if (edge_set[gv]) begin
          edge_pend_q[gv] <= 1'b1;
        end else if (take_mask && win_idx == 4'(gv)) begin
          edge_pend_q[gv] <= 1'b0;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          per_pend_q[gv] <= 1'b0;
        end else if (periph_flag[gv] && periph_en[gv]) begin
          per_pend_q[gv] <= 1'b1;
        end else if (periph_clr[gv]) begin
          per_pend_q[gv] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  // level field from bits 5 and 3
  assign cur_lvl = {cc_q[CC_HI_BIT], cc_q[CC_LO_BIT]};
  assign pending = edge_pend_q | per_pend_q;

  always_comb begin
    for (int v = 0; v < NUM_VEC; v++) begin
      rank[v] = lvl_rank(isp_q[v]);
      eligible[v] = pending[v] && (lvl_rank(isp_q[v]) > lvl_rank(cur_lvl));
    end
    rank[0]     = 3'h4;
    eligible[0] = pending[0] && !top_active_q;
    // halted core wakes only on capable vectors
    if (sleep_q == slp_halt) begin
      eligible = eligible & WAKE_MASK;
    end
  end

  nic_prio_sel #(
    .NUM (NUM_VEC),
    .IW  (4)
  ) u_sel (
    .req   (eligible),
    .rank  (rank),
    .valid (win_valid),
    .idx   (win_idx)
  );

  // vectors accepted at instruction end or while asleep; reset and trap at once
  assign boundary  = cpu_req.insn_end || sleep_q != slp_awake;
  assign take      = state_q == st_run &&
                     (reset_pend_q || trap_pend_q || (win_valid && boundary));
  assign take_mask = take && !reset_pend_q && !trap_pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pend_q <= 1'b1;
      trap_pend_q  <= 1'b0;
      top_active_q <= 1'b0;
    end else begin
      if (take) begin
        reset_pend_q <= 1'b0;
      end
      if (cpu_req.insn_end && cpu_req.op == op_trap) begin
        trap_pend_q <= 1'b1;
      end else if (take && !reset_pend_q) begin
        trap_pend_q <= 1'b0;
      end
      if (take_mask && win_idx == 4'h0) begin
        top_active_q <= 1'b1;
      end else if (cpu_req.insn_end && cpu_req.op == op_return_from_handler)
      begin
        top_active_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Entry sequence
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= st_run;
      sel_nmi_q   <= 1'b0;
      sel_reset_q <= 1'b0;
      sel_trap_q  <= 1'b0;
      sel_idx_q   <= 4'h0;
      cpu_ctl     <= '0;
    end else begin
      cpu_ctl.push     <= 1'b0;
      cpu_ctl.vec_load <= 1'b0;
      cpu_ctl.fetch    <= 1'b0;
      cpu_ctl.wake     <= 1'b0;
      cpu_ctl.stopped  <= sleep_q != slp_awake && !take;
      case (state_q)
        st_run: begin
          if (take) begin
            sel_nmi_q    <= reset_pend_q || trap_pend_q || win_idx == 4'h0;
            sel_reset_q  <= reset_pend_q;
            // Trap pend clears on take, so the choice is kept here
            sel_trap_q   <= trap_pend_q;
            sel_idx_q    <= win_idx;
            cpu_ctl.hold <= 1'b1;
            cpu_ctl.wake <= sleep_q != slp_awake;
            if (reset_pend_q) begin
              state_q <= st_vector;
            end else begin
              state_q      <= st_push;
              cpu_ctl.push <= 1'b1;
              cpu_ctl.item <= push_pcl;
            end
          end
        end
        st_push: begin
          // PC, X, A then CC pushed
          if (cpu_ctl.item == push_cc) begin
            state_q          <= st_vector;
            cpu_ctl.vec_load <= 1'b1;
          end else begin
            cpu_ctl.push <= 1'b1;
            cpu_ctl.item <= nic_push_t'(cpu_ctl.item + 3'h1);
          end
          cpu_ctl.vec_addr <= sel_reset_q ? VEC_RESET :
                              sel_trap_q ? VEC_TRAP :
                              VEC_TOP - 16'(sel_idx_q) * VEC_STEP;
        end
        st_vector: begin
          if (sel_reset_q) begin
            cpu_ctl.vec_load <= 1'b1;
            cpu_ctl.vec_addr <= VEC_RESET;
          end
          state_q <= st_fetch;
        end
        default: begin
          cpu_ctl.fetch <= 1'b1;
          cpu_ctl.hold  <= 1'b0;
          state_q       <= st_run;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Condition code and sleep
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= CC_RESET;
    end else if (state_q == st_vector) begin
      {cc_q[CC_HI_BIT], cc_q[CC_LO_BIT]} <= sel_nmi_q ? LVL3 :
                                            isp_q[sel_idx_q];
    end else if (cpu_req.insn_end) begin
      case (cpu_req.op)
        op_return_from_handler, op_pop_cc: cc_q <= cpu_req.pop_cc | CC_ONES;
        // unmask loads 10, mask loads 11
        op_unmask_all, op_wait_for_irq, op_halt:
          {cc_q[CC_HI_BIT], cc_q[CC_LO_BIT]} <= LVL0;
        op_mask_all: {cc_q[CC_HI_BIT], cc_q[CC_LO_BIT]} <= LVL3;
        default: cc_q <= cc_q;
      endcase
    end else if (apb_wr && paddr == OFS_CC) begin
      cc_q <= pwdata[7:0] | CC_ONES;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= slp_awake;
    end else if (take) begin
      // any accepted source ends the stop
      sleep_q <= slp_awake;
    end else if (cpu_req.insn_end && cpu_req.op == op_wait_for_irq) begin
      sleep_q <= slp_wait;
    end else if (cpu_req.insn_end && cpu_req.op == op_halt) begin
      sleep_q <= slp_halt;
    end
  end

  assign cc_value = cc_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_vec_range: assert property (
    cpu_ctl.vec_load |-> cpu_ctl.vec_addr >= VEC_BOTTOM &&
                         !cpu_ctl.vec_addr[0])
    else $error("vector outside top table");
  a_entry_stack: assert property (
    cpu_ctl.push && cpu_ctl.item == push_pcl |=>
    cpu_ctl.item == push_pch ##1 cpu_ctl.item == push_x ##1
    cpu_ctl.item == push_a ##1 cpu_ctl.item == push_cc ##1
    cpu_ctl.vec_load ##2 cpu_ctl.fetch)
    else $error("stacking order broken");
  a_at_boundary: assert property (
    take_mask |-> cpu_req.insn_end || sleep_q != slp_awake)
    else $error("entry inside an instruction");
  a_level_load: assert property (
    state_q == st_vector && !sel_nmi_q |=>
    cur_lvl == $past(isp_q[sel_idx_q]))
    else $error("level not from priority");
  a_nmi_level: assert property (
    state_q == st_vector && sel_nmi_q |=> cur_lvl == LVL3)
    else $error("non-maskable level not 3");
  a_return_lvl: assert property (
    cpu_req.insn_end && cpu_req.op == op_return_from_handler &&
    state_q != st_vector |=>
    cur_lvl == {$past(cpu_req.pop_cc[5]), $past(cpu_req.pop_cc[3])})
    else $error("return did not restore level");
  a_mask_rank: assert property (
    take_mask && win_idx != 4'h0 |->
    lvl_rank(isp_q[win_idx]) > lvl_rank(cur_lvl))
    else $error("maskable taken at or below level");
  a_unmask_all: assert property (
    cpu_req.insn_end && cpu_req.op == op_unmask_all &&
    state_q != st_vector |=> cur_lvl == LVL0)
    else $error("unmask did not load 10");
  a_halt_wake: assert property (
    take_mask && sleep_q == slp_halt |-> WAKE_MASK[win_idx])
    else $error("stop left by incapable source");

  c_trap_entry: cover property (take && trap_pend_q);
  c_tli_nest: cover property (take_mask && win_idx == 4'h0 &&
                              cur_lvl == LVL3);
  c_halt_exit: cover property (take && sleep_q == slp_halt);
  c_return: cover property (cpu_req.insn_end &&
                            cpu_req.op == op_return_from_handler);
endmodule
`default_nettype wire

// >>> core/nic_pkg.sv
// Purpose: Shared constants and types of the nested interrupt controller
// Assumes: One core clock, APB register access
// Notes:   Level codes follow the condition code register encoding
package nic_pkg;
  // ----------------------------------------
  // Sizes and vector map
  // ----------------------------------------
  localparam int          NUM_VEC     = 14;
  localparam int          NUM_GRP     = 4;
  localparam int          GRP_PINS    = 4;
  localparam int          EXT_VEC0    = 2;
  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] VEC_TRAP    = 16'hfffc;
  localparam logic [15:0] VEC_TOP     = 16'hfffa;
  localparam logic [15:0] VEC_BOTTOM  = 16'hffe0;
  localparam logic [15:0] VEC_STEP    = 16'h0002;
  localparam logic [13:0] WAKE_MASK   = 14'h20ff;
  // ----------------------------------------
  // Condition code and levels
  // ----------------------------------------
  localparam int          CC_HI_BIT   = 5;
  localparam int          CC_LO_BIT   = 3;
  localparam logic [7:0]  CC_RESET    = 8'hea;
  localparam logic [7:0]  CC_ONES     = 8'hc0;
  localparam logic [1:0]  LVL0        = 2'h2;
  localparam logic [1:0]  LVL1        = 2'h1;
  localparam logic [1:0]  LVL2        = 2'h0;
  localparam logic [1:0]  LVL3        = 2'h3;
  localparam logic [7:0]  PRIO_RESET  = 8'hff;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFS_CC      = 12'h000;
  localparam logic [11:0] OFS_PRIO0   = 12'h004;
  localparam logic [11:0] OFS_PRIO3   = 12'h010;
  localparam logic [11:0] OFS_EXT_SEL = 12'h014;
  localparam logic [11:0] OFS_CTRL    = 12'h018;
  localparam logic [11:0] OFS_STATUS  = 12'h01c;
  localparam int          CTRL_TOP_RISE = 0;
  localparam int          CTRL_EXT_RISE = 1;
  localparam logic [4:0]  CTRL_RESET  = 5'h00;
  localparam logic [15:0] EXT_SEL_RESET = 16'h0000;

  typedef enum logic [2:0] {
    op_none                = 3'h0,
    op_trap                = 3'h1,
    op_return_from_handler = 3'h2,
    op_unmask_all          = 3'h3,
    op_mask_all            = 3'h4,
    op_wait_for_irq        = 3'h5,
    op_halt                = 3'h6,
    op_pop_cc              = 3'h7
  } nic_op_t;

  typedef enum logic [2:0] {
    push_pcl = 3'h0,
    push_pch = 3'h1,
    push_x   = 3'h2,
    push_a   = 3'h3,
    push_cc  = 3'h4
  } nic_push_t;

  typedef enum logic [1:0] {
    st_run    = 2'h0,
    st_push   = 2'h1,
    st_vector = 2'h2,
    st_fetch  = 2'h3
  } nic_state_t;

  typedef enum logic [1:0] {
    slp_awake = 2'h0,
    slp_wait  = 2'h1,
    slp_halt  = 2'h2
  } nic_sleep_t;

  typedef struct packed {
    logic       insn_end;
    nic_op_t    op;
    logic [7:0] pop_cc;
  } nic_cpu_req_t;

  typedef struct packed {
    logic        hold;
    logic        push;
    nic_push_t   item;
    logic        vec_load;
    logic [15:0] vec_addr;
    logic        fetch;
    logic        stopped;
    logic        wake;
  } nic_cpu_ctl_t;
endpackage

// >>> core/nic_prio_sel.sv
// Purpose: Picks the winning request by rank, then by fixed order
// Assumes: Lower index means higher fixed hardware priority
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module nic_prio_sel #(
  parameter int NUM = 14,
  parameter int IW  = 4
) (
  input  wire logic [NUM-1:0]      req,
  input  wire logic [NUM-1:0][2:0] rank,
  output logic                     valid,
  output logic [IW-1:0]            idx
);
  logic [2:0] best;

  always_comb begin
    valid = 1'b0;
    idx   = '0;
    best  = 3'h0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (req[i] && (!valid || rank[i] >= best)) begin
        valid = 1'b1;
        idx   = IW'(i);
        best  = rank[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/nic_cpu_model.sv
// Purpose: CPU core stand-in driving instruction ends and ops
// Assumes: Obeys hold and stopped from the controller
// Notes:   Plain instructions end every fourth cycle
`timescale 1ns/10ps
`default_nettype none
module nic_cpu_model
  import nic_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire nic_cpu_ctl_t cpu_ctl,
  input  wire logic         want,
  input  wire nic_op_t      op,
  input  wire logic [7:0]   pop_cc,
  output nic_cpu_req_t      cpu_req
);
  // ----------------------------------------
  // Instruction stream
  // ----------------------------------------
  logic [1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 2'h0;
      cpu_req <= '0;
    end else begin
      cnt_q            <= cnt_q + 2'h1;
      // Never two ends in a row, so a commanded op is seen once
      cpu_req.insn_end <= !cpu_ctl.hold && !cpu_ctl.stopped &&
                          !cpu_req.insn_end && (want || cnt_q == 2'h3);
      cpu_req.op       <= want ? op : op_none;
      cpu_req.pop_cc   <= pop_cc;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_nested_vectored_irq_control.sv
// Purpose: Self-checking bench of the nested interrupt controller
// Assumes: Registers over APB, CPU played by nic_cpu_model
// Notes:   Halt wake driven through pin group 0
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_nested_vectored_irq_control import nic_pkg::*;;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic         pclk, pready, pslverr, err;
  logic         presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic         top_irq_pin = 0, want = 0;
  logic [15:0]  ext_pin = 16'h0000;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, r;
  logic [7:0]   cc_value, pop_cc = 8'h00;
  logic [13:0]  periph_flag = 14'h0, periph_en = 14'h0, periph_clr = 14'h0;
  nic_op_t      op = op_none;
  nic_cpu_req_t cpu_req;
  nic_cpu_ctl_t cpu_ctl;
  int           checks_done = 0, fails = 0, npush = 0, nwake = 0, k;

  nic_core nic_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_ctl(cpu_ctl), .cc_value(cc_value),
    .top_irq_pin(top_irq_pin), .ext_pin(ext_pin),
    .periph_flag(periph_flag),
    .periph_en(periph_en), .periph_clr(periph_clr));
  nic_cpu_model nic_cpu_model_i (.pclk(pclk), .presetn(presetn),
    .cpu_ctl(cpu_ctl), .want(want), .op(op), .pop_cc(pop_cc),
    .cpu_req(cpu_req));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [1:0] lvl();
    return {cc_value[CC_HI_BIT], cc_value[CC_LO_BIT]};
  endfunction

  always @(posedge pclk) begin
    if (cpu_ctl.wake) nwake++;
    if (cpu_ctl.fetch) npush = 0;
    else if (cpu_ctl.push) begin
      `CHK("push item", 3'(npush), 3'(cpu_ctl.item))
      npush++;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tmo(input int i, input int m);
    if (i >= m) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    tmo(i, 50);
  endtask

  task automatic do_op(input nic_op_t o, input logic [7:0] c);
    int i;
    @(posedge pclk);
    want   <= 1'b1;
    op     <= o;
    pop_cc <= c;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (cpu_req.insn_end === 1'b1 && cpu_req.op === o) break;
    end
    want <= 1'b0;
    tmo(i, 100);
  endtask

  task automatic entry(input logic [15:0] a, input int n,
                       input logic [1:0] l);
    int i;
    for (i = 0; i < 200 && cpu_ctl.vec_load !== 1'b1; i++)
      @(posedge pclk);
    tmo(i, 200);
    `CHK("vector", a, cpu_ctl.vec_addr)
    `CHK("stacked", n, npush)
    for (i = 0; i < 20 && cpu_ctl.fetch !== 1'b1; i++)
      @(posedge pclk);
    tmo(i, 20);
    `CHK("entry level", l, lvl())
  endtask

  task automatic wait_lvl(input logic [1:0] l);
    int i;
    for (i = 0; i < 20 && lvl() !== l; i++)
      @(posedge pclk);
    `CHK("level", l, lvl())
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    `CHK("cc reset", CC_RESET, cc_value)
    presetn <= 1'b1;
    entry(VEC_RESET, 0, LVL3);
    for (k = 0; k < 4; k++) begin
      apb(1'b0, OFS_PRIO0 + 12'(4 * k), 32'h0);
      `CHK("prio reset", 32'h000000ff, r)
    end
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, OFS_PRIO0, 32'h000000cf);
    apb(1'b1, OFS_PRIO0, 32'h00000064);
    apb(1'b0, OFS_PRIO0, 32'h0);
    `CHK("level0 write", 32'h00000044, r)
    apb(1'b1, OFS_PRIO3, 32'h00000002);
    apb(1'b0, OFS_PRIO3, 32'h0);
    `CHK("last prio reg", 32'h000000f3, r)
    apb(1'b1, OFS_PRIO0 + 12'h008, 32'h000000fd);
    apb(1'b1, OFS_CTRL, 32'h00000001);
    periph_en   <= 14'h0300;
    periph_flag <= 14'h0300;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("masked pending", 2'h3, r[9:8])
    `CHK("no entry", 1'b0, cpu_ctl.hold)
    // Vector 9 ranks above 8 despite lower fixed order
    do_op(op_unmask_all, 8'h00);
    entry(VEC_TOP - 16'h0012, 5, LVL3);
    do_op(op_trap, 8'h00);
    entry(VEC_TRAP, 5, LVL3);
    top_irq_pin <= 1'b1;
    entry(VEC_TOP, 5, LVL3);
    do_op(op_return_from_handler, CC_RESET);
    do_op(op_return_from_handler, CC_RESET);
    periph_flag <= 14'h0100;
    periph_clr  <= 14'h0200;
    @(posedge pclk) periph_clr <= 14'h0000;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("dropped", 1'b0, r[9])
    do_op(op_return_from_handler, 8'he2);
    entry(VEC_TOP - 16'h0010, 5, LVL1);
    periph_flag <= 14'h0000;
    periph_clr  <= 14'h0100;
    @(posedge pclk) periph_clr <= 14'h0000;
    do_op(op_return_from_handler, 8'he2);
    wait_lvl(LVL0);
    do_op(op_mask_all, 8'h00);
    wait_lvl(LVL3);
    do_op(op_unmask_all, 8'h00);
    wait_lvl(LVL0);
    // Group 0 pins 0 and 1, rising edge; top pin stays rising
    apb(1'b1, OFS_EXT_SEL, 32'h00000003);
    apb(1'b1, OFS_CTRL, 32'h00000003);
    do_op(op_halt, 8'h00);
    periph_flag <= 14'h0200;
    repeat (8) @(posedge pclk);
    `CHK("halt held", 1'b1, cpu_ctl.stopped)
    ext_pin <= 16'h0002;
    entry(VEC_TOP - 16'h0004, 5, LVL2);
    `CHK("wake", 1, nwake)
    entry(VEC_TOP - 16'h0012, 5, LVL3);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("edge cleared", 1'b0, r[2])
    report_and_stop();
  end
endmodule
`default_nettype wire
